// ---- stc_defs.svh ----
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: included by the design file and the testbench
// Notes: definitions only
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define STC_OFS_LOW 12'h000
`define STC_OFS_HIGH 12'h004
`define STC_OFS_CTRL 12'h008
`define STC_OFS_FLAGS 12'h00C
`define STC_OFS_ENABLES 12'h010
`define STC_OFS_CMP 12'h014
`define STC_OFS_CMPMODE 12'h018
`define STC_CTRL_RESET 8'h00
`define STC_CTRL_MASK 8'hBF
`define STC_BIT_RUN 0
`define STC_BIT_SRC 1
`define STC_BIT_SYNC 2
`define STC_BIT_OSC 3
`define STC_BIT_PS_LO 4
`define STC_BIT_WIDE 7
`define STC_MODE_SPECIAL 4'hB
`define STC_CMP_RESET 16'hFFFF
`endif

// ---- stc_pin_model.sv ----
// Purpose: far-side model of the timer's count pins
// Assumes: a burst is requested by a one-cycle go pulse
// Notes: pins stand low between bursts; no free-running crystal
`timescale 1ns/10ps
module stc_pin_model (
  // Clock
  input wire logic hclk,
  // Burst request
  input wire logic go,
  input wire logic use_xtal,
  input wire logic [7:0] n_edges,
  // Count pins
  output logic ext_pin,
  output logic xtal_pin
);
  // ****
  // Edge generator
  // ****
  logic [9:0] left = 10'h000;
  // Four cycles per edge, so a synchroniser never misses one
  always_ff @(posedge hclk) begin
    if (go) begin
      left <= {n_edges, 2'h0};
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
  end
  assign ext_pin = !use_xtal && left[1];
  assign xtal_pin = use_xtal && left[1];
endmodule : stc_pin_model

// ---- stc_pkg.sv ----
// Purpose: types of the 16-bit timer/counter
// Assumes: stc_defs.svh holds the numbers
// Notes: control register layout as a packed struct
package stc_pkg;
  typedef struct packed {
    logic wide_access_mode;
    logic unused6;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic external_sync_control;
    logic count_source_select;
    logic run_enable;
  } stc_ctrl_t;
  typedef enum logic [1:0] {
    STC_DIV1, STC_DIV2, STC_DIV4, STC_DIV8
  } stc_div_t;
endpackage : stc_pkg

// ---- stc_timer.sv ----
// Purpose: 16-bit timer/counter with AHB-Lite register slave
// Assumes: hclk is the instruction clock; pins synchronous to hclk
// Notes: asynchronous counting is modelled on the raw input edge
// Summary of operation
// - Source select clear: count every instruction cycle.
// - Source select set: count rising edges of external input or crystal.
// - Crystal enabled forces both crystal pins to inputs, ignoring direction.
// - Compare unit clear input returns count to zero.
// - Crystal oscillator starts on enable and keeps running in sleep.
// - Count runs 0000h to FFFFh then wraps to 0000h.
// - Each wrap sets sticky overflow flag.
// - Overflow request passes only while its enable bit is set.
// - Special-trigger compare mode: match clears counter, starts conversion.
// - Special-trigger clear does not set overflow flag.
// - Trigger clear guaranteed only in timer or synchronised counter mode.
// - Software write in same cycle as trigger clear wins.
// - Compare value acts as the period in special-trigger mode; here compare_value_pair is only stored, the match arrives on compare_match.
// - Wide mode: high-byte address selects holding buffer.
// - Wide mode: low-byte read copies live high byte into buffer.
// - Wide mode: high write fills buffer; low write loads both bytes.
// - Wide mode: no direct path to live high byte.
// - Wide mode: high write leaves prescaler; low write clears it.
// - Prescale codes 00..11 divide count clock by 1, 2, 4, 8.
// - Oscillator enable bit on turns crystal on, off shuts it off.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "stc_defs.svh"
module stc_timer
  import stc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic external_count_input,
  input wire logic crystal_input_pin,
  input wire logic [1:0] port_c_direction,
  output logic [1:0] crystal_pin_dir,
  output logic crystal_osc_run,
  // Compare and converter
  input wire logic compare_match,
  input wire logic adc_enable,
  output logic adc_start,
  // Interrupt request
  output logic overflow_irq
);
  // ******************************************************************
  // Bus slave
  // ******************************************************************
  stc_ctrl_t ctrl;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic [7:0] hi_buf;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [15:0] compare_value_pair;
  logic [3:0] compare_mode_field;
  logic [2:0] prescale_cnt;
  logic ext_q;
  logic [11:0] a_addr;
  logic a_wr;
  logic take;
  logic wr_lo;
  logic wr_hi;
  logic rd_lo;
  logic wr_ctrl;
  logic wr_flags;
  logic [7:0] wbyte;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wbyte = hwdata[7:0];
  assign wr_lo = a_wr && (a_addr == `STC_OFS_LOW);
  assign wr_hi = a_wr && (a_addr == `STC_OFS_HIGH);
  assign wr_ctrl = a_wr && (a_addr == `STC_OFS_CTRL);
  assign wr_flags = a_wr && (a_addr == `STC_OFS_FLAGS);
  assign rd_lo = take && !hwrite && (haddr == `STC_OFS_LOW);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr <= 12'h000;
      a_wr <= 1'b0;
    end else begin
      a_addr <= {haddr[11:2], 2'b00};
      a_wr <= take && hwrite;
    end
  end

  // Read data registered in the address phase; zero for unmapped words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      unique case ({haddr[11:2], 2'b00})
        `STC_OFS_LOW: hrdata <= {24'h000000, cnt_lo};
        `STC_OFS_HIGH: hrdata <= {24'h000000,
          ctrl.wide_access_mode ? hi_buf : cnt_hi};
        `STC_OFS_CTRL: hrdata <= {24'h000000, ctrl};
        `STC_OFS_FLAGS: hrdata <= {31'h0, overflow_flag};
        `STC_OFS_ENABLES: hrdata <= {31'h0, overflow_irq_enable};
        `STC_OFS_CMP: hrdata <= {16'h0000, compare_value_pair};
        `STC_OFS_CMPMODE: hrdata <= {28'h0, compare_mode_field};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  a_buf_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == `STC_OFS_HIGH && ctrl.wide_access_mode
    |=> hrdata[7:0] == $past(hi_buf))
    else $error("high read missed buffer");
  a_live_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == `STC_OFS_HIGH && !ctrl.wide_access_mode
    |=> hrdata[7:0] == $past(cnt_hi))
    else $error("high read missed live byte");

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `STC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= wbyte & `STC_CTRL_MASK;
    end
  end

  a_osc_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> crystal_osc_run == $past(wbyte[`STC_BIT_OSC]))
    else $error("oscillator run not following enable");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq_enable <= 1'b0;
      compare_value_pair <= `STC_CMP_RESET;
      compare_mode_field <= 4'h0;
    end else begin
      if (a_wr && a_addr == `STC_OFS_ENABLES)
        overflow_irq_enable <= hwdata[0];
      if (a_wr && a_addr == `STC_OFS_CMP)
        compare_value_pair <= hwdata[15:0];
      if (a_wr && a_addr == `STC_OFS_CMPMODE)
        compare_mode_field <= hwdata[3:0];
    end
  end

  // ******************************************************************
  // Crystal oscillator and pins
  // ******************************************************************
  // Oscillator runs on the enable bit alone, so sleep never stops it
  assign crystal_osc_run = ctrl.crystal_osc_enable;
  // Direction 1 means input; enable overrides the port setting
  assign crystal_pin_dir = ctrl.crystal_osc_enable ?
    2'b11 : port_c_direction;

  a_pin_force: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl.crystal_osc_enable |-> crystal_pin_dir == 2'b11)
    else $error("crystal pins not inputs");
  a_pin_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl.crystal_osc_enable |-> crystal_pin_dir == port_c_direction)
    else $error("port direction not passed through");

  // ******************************************************************
  // Count clock selection and prescaler
  // ******************************************************************
  logic src_level;
  logic src_edge;
  logic tick;
  logic ps_done;
  logic sync_mode;
  logic [15:0] cnt;
  logic special;
  logic trig_clear;

  assign src_level = ctrl.crystal_osc_enable ?
    crystal_input_pin : external_count_input;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= src_level;
    end
  end

  assign src_edge = src_level && !ext_q;
  // Timer mode counts every cycle, counter mode counts rising edges
  assign tick = ctrl.run_enable &&
    (ctrl.count_source_select ? src_edge : 1'b1);

  always_comb begin
    unique case (stc_div_t'(ctrl.prescale_select))
      STC_DIV1: ps_done = 1'b1;
      STC_DIV2: ps_done = prescale_cnt[0];
      STC_DIV4: ps_done = &prescale_cnt[1:0];
      STC_DIV8: ps_done = &prescale_cnt;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_cnt <= 3'h0;
    end else if (wr_lo) begin
      prescale_cnt <= 3'h0;
    end else if (tick) begin
      prescale_cnt <= ps_done ? 3'h0 : prescale_cnt + 3'h1;
    end
  end

  a_ps_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_lo |=> prescale_cnt == 3'h0)
    else $error("low write left prescaler");
  a_ps_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hi && ctrl.wide_access_mode && !tick |=> $stable(prescale_cnt))
    else $error("high write moved prescaler");

  // ******************************************************************
  // Counter, trigger clear and overflow
  // ******************************************************************
  assign cnt = {cnt_hi, cnt_lo};
  assign sync_mode = !ctrl.count_source_select ||
    !ctrl.external_sync_control;
  assign special = compare_mode_field == `STC_MODE_SPECIAL;
  // Asynchronous counter mode does not honour the trigger clear
  assign trig_clear = special && compare_match && sync_mode;
  assign adc_start = special && compare_match && adc_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
    end else if (wr_lo) begin
      cnt_lo <= wbyte;
      if (ctrl.wide_access_mode)
        cnt_hi <= hi_buf;
    end else if (wr_hi && !ctrl.wide_access_mode) begin
      cnt_hi <= wbyte;
    end else if (trig_clear) begin
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
    end else if (tick && ps_done) begin
      {cnt_hi, cnt_lo} <= cnt + 16'h0001;
    end
  end

  a_trig_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_clear && !wr_lo && !wr_hi |=> cnt == 16'h0000)
    else $error("trigger did not clear count");
  a_write_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_clear && wr_lo |=> cnt_lo == $past(wbyte))
    else $error("write lost to trigger");
  a_run_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl.run_enable && !a_wr && !trig_clear |=> $stable(cnt))
    else $error("count moved while stopped");
  a_timer_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl.run_enable && !ctrl.count_source_select &&
    ctrl.prescale_select == 2'b00 && !a_wr && !trig_clear
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("timer did not step");
  a_edge_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl.run_enable && ctrl.count_source_select && src_edge &&
    ctrl.prescale_select == 2'b00 && !a_wr && !trig_clear
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter missed an edge");
  a_edge_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl.count_source_select && !src_edge && !a_wr && !trig_clear
    |=> $stable(cnt))
    else $error("counter moved without an edge");
  a_async_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl.count_source_select && ctrl.external_sync_control |-> !trig_clear)
    else $error("trigger clear in asynchronous mode");
  a_mode_guard: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !special |-> !trig_clear && !adc_start)
    else $error("trigger action outside special mode");
  a_wide_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_lo && ctrl.wide_access_mode |=> cnt_hi == $past(hi_buf))
    else $error("low write did not load high byte");
  a_narrow_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hi && !ctrl.wide_access_mode |=> cnt_hi == $past(wbyte))
    else $error("high write did not reach count");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_buf <= 8'h00;
    end else if (wr_hi && ctrl.wide_access_mode) begin
      hi_buf <= wbyte;
    end else if (rd_lo && ctrl.wide_access_mode) begin
      hi_buf <= cnt_hi;
    end
  end

  a_buf_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_lo && ctrl.wide_access_mode && !wr_hi |=> hi_buf == $past(cnt_hi))
    else $error("high buffer not loaded");
  a_buf_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hi && ctrl.wide_access_mode |=> hi_buf == $past(wbyte))
    else $error("high write missed buffer");
  a_buf_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl.wide_access_mode |=> $stable(hi_buf))
    else $error("buffer moved in narrow mode");

  logic wrap;
  assign wrap = !wr_lo && !(wr_hi && !ctrl.wide_access_mode) &&
    !trig_clear && tick && ps_done && cnt == 16'hFFFF;

  // Set wins over a same-cycle software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_flags && !hwdata[0]) begin
      overflow_flag <= 1'b0;
    end
  end

  a_wrap_sets_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wrap |=> overflow_flag && cnt == 16'h0000)
    else $error("overflow flag not set on wrap");
  a_trig_no_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_clear && !wr_lo && !overflow_flag && !wrap |=> !overflow_flag)
    else $error("trigger clear set overflow");
  a_flag_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    overflow_flag && !wr_flags |=> overflow_flag)
    else $error("overflow flag dropped by itself");
  a_flag_source: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overflow_flag && !wrap |=> !overflow_flag)
    else $error("overflow flag set without a wrap");

  assign overflow_irq = overflow_flag && overflow_irq_enable;

  a_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    overflow_irq |-> overflow_flag && overflow_irq_enable)
    else $error("irq without enable");
  a_irq_mask: assert property (
    @(posedge hclk) disable iff (!hresetn)
    overflow_flag && overflow_irq_enable |-> overflow_irq)
    else $error("enabled overflow gave no irq");
endmodule : stc_timer

// ---- tb_top.sv ----
// Purpose: self-checking bench of the 16-bit timer/counter
// Assumes: zero-wait AHB-Lite slave, one master
// Notes: each run-task window between run on and off is 40 cycles
`timescale 1ns/10ps
`include "stc_defs.svh"
module tb_top;
  import stc_pkg::*;
  localparam logic [11:0] ofs_lo = `STC_OFS_LOW;
  localparam logic [11:0] ofs_hi = `STC_OFS_HIGH;
  localparam logic [11:0] ofs_ctl = `STC_OFS_CTRL;
  localparam logic [11:0] ofs_flg = `STC_OFS_FLAGS;
  localparam logic [11:0] ofs_ien = `STC_OFS_ENABLES;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout, hresp, crystal_osc_run, adc_start, overflow_irq;
  logic external_count_input, crystal_input_pin;
  logic [1:0] port_c_direction = 2'h1;
  logic [1:0] crystal_pin_dir;
  logic compare_match = 1'b0;
  logic adc_enable = 1'b0;
  logic go = 1'b0;
  logic use_xtal = 1'b0;
  logic [7:0] n_edges = 8'h00;
  int fails = 0;
  int n_checks = 0;
  always #2 hclk = ~hclk;
  stc_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .external_count_input, .crystal_input_pin, .port_c_direction,
    .crystal_pin_dir, .crystal_osc_run, .compare_match, .adc_enable,
    .adc_start, .overflow_irq);
  stc_pin_model far (.hclk, .go, .use_xtal, .n_edges,
    .ext_pin(external_count_input), .xtal_pin(crystal_input_pin));
  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Trig raises the compare match for the data-phase cycle
  task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] d, input logic trig);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    compare_match <= trig;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    compare_match <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 1'b0);
    chk(r, e);
  endtask : rd
  task automatic run(input logic [7:0] c);
    wr(ofs_ctl, {24'h0, c});
    repeat (38) @(posedge hclk);
    wr(ofs_ctl, {24'h0, c & 8'hFE});
  endtask : run
  task automatic pulse(input logic e);
    compare_match <= 1'b1;
    @(posedge hclk);
    chk(32'(adc_start), 32'(e));
    compare_match <= 1'b0;
  endtask : pulse
  task automatic edges(input logic x, input logic [7:0] n);
    use_xtal <= x;
    n_edges <= n;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (4 * n + 8) @(posedge hclk);
  endtask : edges
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(ofs_ctl, 32'h0);
    rd(ofs_flg, 32'h0);
    rd(ofs_ien, 32'h0);
    rd(`STC_OFS_CMP, {16'h0, `STC_CMP_RESET});
    rd(12'h01C, 32'h0);
    chk(32'(hresp), 32'h0);
    wr(ofs_ctl, 32'hFF);
    rd(ofs_ctl, {24'h0, `STC_CTRL_MASK});
    wr(ofs_ctl, 32'h0);
  endtask : t_regs
  task automatic t_prescale;
    for (int p = 0; p < 4; p++) begin
      wr(ofs_lo, 32'h0);
      wr(ofs_hi, 32'h0);
      run({2'h0, 2'(p), 4'h1});
      rd(ofs_lo, 32'(40 >> p));
      repeat (6) @(posedge hclk);
      rd(ofs_lo, 32'(40 >> p));
    end
  endtask : t_prescale
  task automatic t_overflow;
    wr(ofs_hi, 32'hFF);
    wr(ofs_lo, 32'hF0);
    run(8'h01);
    rd(ofs_lo, 32'h18);
    rd(ofs_hi, 32'h0);
    rd(ofs_flg, 32'h1);
    chk(32'(overflow_irq), 32'h0);
    wr(ofs_ien, 32'h1);
    rd(ofs_flg, 32'h1);
    chk(32'(overflow_irq), 32'h1);
    wr(ofs_ien, 32'h0);
    wr(ofs_flg, 32'h0);
    rd(ofs_flg, 32'h0);
    chk(32'(overflow_irq), 32'h0);
  endtask : t_overflow
  task automatic t_trigger;
    wr(`STC_OFS_CMPMODE, 32'(`STC_MODE_SPECIAL));
    wr(ofs_hi, 32'h12);
    wr(ofs_lo, 32'h34);
    adc_enable <= 1'b1;
    pulse(1'b1);
    rd(ofs_lo, 32'h0);
    rd(ofs_hi, 32'h0);
    rd(ofs_flg, 32'h0);
    wr(ofs_hi, 32'h12);
    bus(ofs_lo, 1'b1, 32'h55, 1'b1);
    rd(ofs_lo, 32'h55);
    rd(ofs_hi, 32'h12);
    wr(ofs_ctl, 32'h06);
    adc_enable <= 1'b0;
    pulse(1'b0);
    rd(ofs_lo, 32'h55);
    wr(`STC_OFS_CMPMODE, 32'h0);
  endtask : t_trigger
  task automatic t_counter;
    wr(ofs_lo, 32'h0);
    wr(ofs_ctl, 32'h03);
    edges(1'b0, 8'h05);
    wr(ofs_ctl, 32'h0);
    rd(ofs_lo, 32'h5);
    wr(ofs_ctl, 32'h0F);
    rd(ofs_ctl, 32'h0F);
    chk(32'(crystal_osc_run), 32'h1);
    chk(32'(crystal_pin_dir), 32'h3);
    repeat (8) @(posedge hclk);
    edges(1'b1, 8'h03);
    wr(ofs_ctl, 32'h0);
    rd(ofs_lo, 32'h8);
    chk(32'(crystal_osc_run), 32'h0);
    chk(32'(crystal_pin_dir), 32'h1);
  endtask : t_counter
  task automatic t_wide;
    wr(ofs_hi, 32'h12);
    wr(ofs_lo, 32'h34);
    wr(ofs_ctl, 32'h80);
    rd(ofs_lo, 32'h34);
    rd(ofs_hi, 32'h12);
    wr(ofs_hi, 32'hAB);
    wr(ofs_ctl, 32'h0);
    rd(ofs_hi, 32'h12);
    wr(ofs_ctl, 32'h80);
    wr(ofs_lo, 32'hCD);
    wr(ofs_ctl, 32'h0);
    rd(ofs_hi, 32'hAB);
    rd(ofs_lo, 32'hCD);
  endtask : t_wide
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_prescale;
    t_overflow;
    t_trigger;
    t_counter;
    t_wide;
    final_report;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    #40000;
    fails++;
    final_report;
  end
endmodule : tb_top
